// File: design/prc_map.vh
// register map, field positions and timing counts of the target response control
`ifndef PRC_MAP_VH
`define PRC_MAP_VH
// =============================================================
// register offsets
`define PRC_CTRL_OFS      12'h000
`define PRC_STAT_OFS      12'h004
// =============================================================
// control register fields
`define PRC_WIN_LSB       16
`define PRC_WIN_MSB       21
`define PRC_RD_MUL_BIT    4
`define PRC_RD_LN_BIT     3
`define PRC_RD_BIT        2
`define PRC_TOUT_DIS_BIT  1
`define PRC_CFG_DONE_BIT  0
`define PRC_CTRL_WMASK    32'h003F001E
`define PRC_CTRL_RST      32'h00000000
// =============================================================
// status register fields
`define PRC_ST_STATE_LSB  0
`define PRC_ST_STATE_MSB  2
`define PRC_ST_RETRY_LSB  8
`define PRC_ST_RETRY_MSB  15
// =============================================================
// timing counts
`define PRC_TIMEOUT_CLKS  5'h10
`define PRC_LOAD_CYCLES   4'h8
// =============================================================
// bus commands
`define PRC_CMD_MEM_RD    4'h6
`define PRC_CMD_MEM_WR    4'h7
`define PRC_CMD_MEM_RDM   4'hC
`define PRC_CMD_MEM_RDL   4'hE
`endif

// File: design/prc_resp_timer.v
// link-clock timeout counter for the target wait phase
`timescale 1ns/1ps
`include "prc_map.vh"
module prc_resp_timer
(
	input  wire       pclk,
	input  wire       presetn,
	input  wire       ce,
	input  wire       clear,
	input  wire       tick,
	output reg        expired_q
);
	// =============================================================
	// counter
	reg  [4:0] count_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_q   <= 5'h00;
			expired_q <= 1'b0;
		end
		else if (ce)
		begin
			if (clear)
			begin
				count_q   <= 5'h00;
				expired_q <= 1'b0;
			end
			else if (tick && !expired_q)
			begin
				count_q   <= count_q + 5'h01;
				// 16 link clocks counted
				expired_q <= (count_q == (`PRC_TIMEOUT_CLKS - 5'h01));
			end
		end
	end
endmodule

// File: design/prc_target_ctrl.v
// target response control: APB register, config load and PCI target termination
`timescale 1ns/1ps
`include "prc_map.vh"
module prc_target_ctrl
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        pci_clk,
	input  wire        pci_frame_n,
	input  wire        pci_irdy_n,
	input  wire [3:0]  pci_cbe_n,
	input  wire [5:0]  window_hit,
	input  wire        data_ready,
	output reg         devsel_n_o,
	output reg         devsel_oe,
	output reg         trdy_n_o,
	output reg         trdy_oe,
	output reg         stop_n_o,
	output reg         stop_oe
);
	// =============================================================
	// states
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_WAIT  = 3'h1;
	localparam [2:0] ST_DATA  = 3'h2;
	localparam [2:0] ST_RETRY = 3'h3;
	localparam [2:0] ST_TURN  = 3'h4;

	function is_read_cmd;
		input [3:0] cmd;
		begin
			is_read_cmd = (cmd == `PRC_CMD_MEM_RD) || (cmd == `PRC_CMD_MEM_RDL) ||
				(cmd == `PRC_CMD_MEM_RDM);
		end
	endfunction

	// =============================================================
	// declarations
	reg  [31:0] ctrl_q;
	reg         cfg_done_q;
	reg  [3:0]  load_cnt_q;
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [7:0]  retry_cnt_q;
	reg  [2:0]  sync1_q;
	reg  [2:0]  sync2_q;
	reg  [3:0]  cbe1_q;
	reg  [3:0]  cbe2_q;
	reg  [5:0]  hit1_q;
	reg  [5:0]  hit2_q;
	reg         clk_prev_q;
	wire        pci_edge;
	wire        frame_n_s;
	wire        irdy_n_s;
	wire [3:0]  cmd_s;
	wire        timeout;
	wire        force_retry;
	wire        decoded;
	wire        apb_access;
	wire [31:0] ctrl_rd;
	wire [31:0] stat_rd;

	// =============================================================
	// pin synchronisers
	// two stages before any logic; edge detect reads stage two only
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// clock bit resets to its idle low, else a false edge follows reset
			sync1_q    <= 3'h6;
			sync2_q    <= 3'h6;
			cbe1_q     <= 4'hF;
			cbe2_q     <= 4'hF;
			hit1_q     <= 6'h00;
			hit2_q     <= 6'h00;
			clk_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			sync1_q    <= {pci_irdy_n, pci_frame_n, pci_clk};
			sync2_q    <= sync1_q;
			cbe1_q     <= pci_cbe_n;
			cbe2_q     <= cbe1_q;
			hit1_q     <= window_hit;
			hit2_q     <= hit1_q;
			clk_prev_q <= sync2_q[0];
		end
	end

	assign pci_edge  = sync2_q[0] & ~clk_prev_q;
	assign frame_n_s = sync2_q[1];
	assign irdy_n_s  = sync2_q[2];
	assign cmd_s     = ~cbe2_q;

	// =============================================================
	// configuration load
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_cnt_q <= 4'h0;
			cfg_done_q <= 1'b0;
		end
		else if (ce && !cfg_done_q)
		begin
			load_cnt_q <= load_cnt_q + 4'h1;
			if (load_cnt_q == (`PRC_LOAD_CYCLES - 4'h1))
				cfg_done_q <= 1'b1;
		end
	end

	// =============================================================
	// target decode and response policy
	// only memory commands claimed, and only through an enabled window
	assign decoded = cfg_done_q &&
		|(hit2_q & ctrl_q[`PRC_WIN_MSB:`PRC_WIN_LSB]) &&
		(is_read_cmd(cmd_s) || (cmd_s == `PRC_CMD_MEM_WR));

	// forcing bits win over timeout disable
	assign force_retry =
		((cmd_s == `PRC_CMD_MEM_RDM) && ctrl_q[`PRC_RD_MUL_BIT]) ||
		((cmd_s == `PRC_CMD_MEM_RDL) && ctrl_q[`PRC_RD_LN_BIT]) ||
		((cmd_s == `PRC_CMD_MEM_RD) && ctrl_q[`PRC_RD_BIT]);

	prc_resp_timer u_timer
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.clear     (state_q != ST_WAIT),
		.tick      (pci_edge),
		.expired_q (timeout)
	);

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (!frame_n_s && decoded)
					state_d = force_retry ? ST_RETRY : ST_WAIT;
			ST_WAIT:
				if (data_ready)
					state_d = ST_DATA;
				else if (timeout && !ctrl_q[`PRC_TOUT_DIS_BIT])
					state_d = ST_RETRY;
			ST_DATA:
				if (!irdy_n_s && frame_n_s)
					state_d = ST_TURN;
				else if (!irdy_n_s && !data_ready)
					state_d = ST_WAIT;
			ST_RETRY:
				if (frame_n_s)
					state_d = ST_TURN;
			ST_TURN:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// pins move only on link clock edges, seen here as pci_edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q     <= ST_IDLE;
			retry_cnt_q <= 8'h00;
			devsel_n_o  <= 1'b1;
			devsel_oe   <= 1'b0;
			trdy_n_o    <= 1'b1;
			trdy_oe     <= 1'b0;
			stop_n_o    <= 1'b1;
			stop_oe     <= 1'b0;
		end
		else if (ce && pci_edge)
		begin
			state_q <= state_d;
			if (state_d == ST_RETRY && state_q != ST_RETRY)
				retry_cnt_q <= retry_cnt_q + 8'h01;
			devsel_n_o <= ~(state_d == ST_WAIT || state_d == ST_DATA || state_d == ST_RETRY);
			trdy_n_o   <= ~(state_d == ST_DATA);
			stop_n_o   <= ~(state_d == ST_RETRY);
			// drivers stay on through turnaround, parked high
			devsel_oe  <= (state_d != ST_IDLE);
			trdy_oe    <= (state_d != ST_IDLE);
			stop_oe    <= (state_d != ST_IDLE);
		end
	end

	// =============================================================
	// APB slave
	// one wait-free access phase; unmapped offsets answer with pslverr
	assign apb_access = psel && penable && pready;
	assign ctrl_rd    = (ctrl_q & `PRC_CTRL_WMASK) | {31'h0, cfg_done_q};
	assign stat_rd    = {16'h0, retry_cnt_q, 5'h00, state_q};

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q  <= `PRC_CTRL_RST;
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			pready <= psel && !penable && !pready;
			// error flag stands only with ready
			pslverr <= 1'b0;
			if (psel && !penable && !pready)
			begin
				pslverr <= (paddr != `PRC_CTRL_OFS) && (paddr != `PRC_STAT_OFS);
				if (paddr == `PRC_CTRL_OFS)
					prdata <= ctrl_rd;
				else if (paddr == `PRC_STAT_OFS)
					prdata <= stat_rd;
				else
					prdata <= 32'h00000000;
			end
			if (apb_access && pwrite && (paddr == `PRC_CTRL_OFS))
				ctrl_q <= pwdata & `PRC_CTRL_WMASK;
		end
	end
endmodule

// File: bench/prc_props.sv
// port checks of the target response control
`timescale 1ns/1ps
module prc_props
(
	input wire        pclk,
	input wire        presetn,
	input wire        ce,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        devsel_n_o,
	input wire        trdy_n_o,
	input wire        stop_n_o
);
	// ========
	// enabled cycles since reset, saturating
	logic [3:0] ld_q;
	wire        rd0 = pready && !pwrite && !pslverr && paddr == 12'h000;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			ld_q <= 4'h0;
		else if (ce && ld_q != 4'hF)
			ld_q <= ld_q + 4'h1;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (psel && !penable && ce |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_load_busy: assert property (rd0 && ld_q < 4'h7 |-> !prdata[0])
		else $error("load flag early");
	a_load_done: assert property (rd0 && ld_q > 4'hA |-> prdata[0])
		else $error("load flag missing");
	a_rsv_zero: assert property (rd0 |-> prdata[31:22] == 10'h0 && prdata[15:5] == 11'h0)
		else $error("reserved bits set");
	a_early_claim: assert property (ld_q < 4'h8 |-> devsel_n_o)
		else $error("claim during load");
	a_retry_form: assert property (!stop_n_o |-> trdy_n_o && !devsel_n_o)
		else $error("bad retry form");
endmodule

// File: bench/prc_pci_master.sv
// pci initiator model for the link side
`timescale 1ns/1ps
module prc_pci_master
(
	output logic       pci_clk,
	output logic       pci_frame_n,
	output logic       pci_irdy_n,
	output logic [3:0] pci_cbe_n,
	output logic [5:0] window_hit,
	input  wire        devsel_n,
	input  wire        trdy_n,
	input  wire        stop_n
);
	int res;
	int nclk;
	initial {pci_clk, pci_frame_n, pci_irdy_n, pci_cbe_n, window_hit} = 13'h0C00;
	// ========
	// clock runs only inside a transaction
	task lk;
		#10 pci_clk = 1'h1;
		#400 pci_clk = 1'h0;
		#390;
	endtask
	task xfer(input logic [3:0] c, input logic [5:0] h);
		#37 res = 0;
		nclk = 0;
		pci_frame_n = 1'h0;
		pci_cbe_n = ~c;
		window_hit = h;
		lk;
		// single data phase; target lines taken just before each rise
		pci_frame_n = 1'h1;
		pci_irdy_n = 1'h0;
		while (res == 0 && nclk < 40)
		begin
			nclk++;
			if (!stop_n)
				res = 2;
			else if (!trdy_n)
				res = 1;
			else if (devsel_n && nclk > 5)
				nclk = 40;
			lk;
		end
		pci_irdy_n = 1'h1;
		// released lines flip, never keep the old value
		pci_cbe_n = c;
		window_hit = ~h;
		repeat (3) lk;
	endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench of the target response control
`timescale 1ns/1ps
`include "prc_map.vh"
module tb_top;
	logic        pclk = 1'h0, presetn = 1'h0, ce = 1'h1, data_ready = 1'h0;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic [3:0]  pci_cbe_n, cm [3] = '{4'h6, 4'hE, 4'hC};
	logic [5:0]  window_hit;
	logic        pci_clk, pci_frame_n, pci_irdy_n, devsel_n_o, devsel_oe;
	logic        trdy_n_o, trdy_oe, stop_n_o, stop_oe;
	int          n_mismatch = 0, samples_checked = 0, seed = 73882, i;
	always #50 pclk = ~pclk;
	prc_target_ctrl dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pci_clk, .pci_frame_n, .pci_irdy_n, .pci_cbe_n,
		.window_hit, .data_ready, .devsel_n_o, .devsel_oe, .trdy_n_o, .trdy_oe, .stop_n_o,
		.stop_oe);
	prc_pci_master pm (.pci_clk, .pci_frame_n, .pci_irdy_n, .pci_cbe_n, .window_hit,
		.devsel_n(devsel_oe ? devsel_n_o : 1'h1), .trdy_n(trdy_oe ? trdy_n_o : 1'h1),
		.stop_n(stop_oe ? stop_n_o : 1'h1));
	// ========
	// tasks
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	function int exp_res(input logic [3:0] c, input logic [5:0] h);
		if ((v[21:16] & h) == 6'h0 || !(c inside {4'h6, 4'h7, 4'hC, 4'hE}))
			return 0;
		if (c == 4'h6 && v[2] || c == 4'hE && v[3] || c == 4'hC && v[4])
			return 2;
		// no data and timeout enabled: retry after the timeout
		if (data_ready !== 1'h1 && !v[1])
			return 2;
		return 1;
	endfunction
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		chk("pready", {31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task pci(input logic [3:0] c, input logic [5:0] h);
		apb(1'h1, `PRC_CTRL_OFS, v);
		pm.xfer(c, h);
		chk("pci result", pm.res, exp_res(c, h));
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#4000000;
		n_mismatch++;
		tally_and_finish;
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `PRC_CTRL_OFS, 32'h0);
		chk("ctrl at reset", rd, `PRC_CTRL_RST);
		repeat (12) @(posedge pclk);
		for (i = 0; i < 6; i++)
		begin
			v = i ? $random(seed) : 32'hFFFFFFFF;
			apb(1'h1, `PRC_CTRL_OFS, v);
			apb(1'h0, `PRC_CTRL_OFS, 32'h0);
			chk("ctrl readback", rd, v & `PRC_CTRL_WMASK | 32'h1);
		end
		apb(1'h1, 12'h010, 32'hFFFFFFFF);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		data_ready <= 1'h1;
		for (i = 0; i < 6; i++)
		begin
			v = 32'h10000 << i;
			pci(4'h6, 6'h01 << i);
			pci(4'h6, ~(6'h01 << i));
		end
		for (i = 0; i < 3; i++)
		begin
			// forcing wins even with data ready and timeout disabled
			v = 32'h10006 | 32'h4 << i;
			pci(cm[i], 6'h01);
			chk("retry at once", pm.nclk <= 2, 32'h1);
			chk("drivers off", {devsel_oe, trdy_oe, stop_oe}, 32'h0);
			pci(4'h7, 6'h01);
		end
		for (i = 0; i < 12; i++)
		begin
			v = $random(seed) & `PRC_CTRL_WMASK;
			pci($random(seed), $random(seed));
		end
		data_ready <= 1'h0;
		v = 32'h10000;
		pci(4'hC, 6'h01);
		chk("timeout span", pm.nclk inside {[15:18]}, 32'h1);
		v = 32'h10002;
		fork
			pci(4'hC, 6'h01);
			begin
				repeat (260) @(posedge pclk);
				data_ready <= 1'h1;
			end
		join
		chk("wait span", pm.nclk > 25, 32'h1);
		// reset again mid-run; a frame inside the load time is not claimed
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		v = 32'h10000;
		apb(1'h1, `PRC_CTRL_OFS, v);
		pm.xfer(4'h6, 6'h01);
		chk("claim in load", pm.res, 32'h0);
		apb(1'h0, `PRC_CTRL_OFS, 32'h0);
		chk("ctrl after load", rd, 32'h00010001);
		apb(1'h0, `PRC_STAT_OFS, 32'h0);
		chk("status idle", rd, 32'h00000000);
		tally_and_finish;
	end
endmodule
bind prc_target_ctrl prc_props u_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .devsel_n_o, .trdy_n_o, .stop_n_o);
